/* inc/rsoc_pkg.sv */
// Package of constants and types for the ratio, source and output control
package rsoc_pkg;

  localparam int          RSOC_RATIO_W       = 32;
  localparam int          RSOC_RATIO_SLOTS   = 4;
  // Frequency format positions of the binary point
  localparam int          RSOC_FRAC_HIRES    = 20;
  localparam int          RSOC_FRAC_HIMULT   = 12;
  localparam int          RSOC_FMT_SHIFT     = RSOC_FRAC_HIRES - RSOC_FRAC_HIMULT;
  // Ratio multiplier and slot select reset values
  localparam logic [2:0]  RSOC_RMOD_RST      = 3'h0;
  localparam logic [1:0]  RSOC_SLOT_RST      = 2'h0;
  // Auxiliary output source codes
  localparam logic [1:0]  RSOC_AUX_REF       = 2'h0;
  localparam logic [1:0]  RSOC_AUX_SYNC      = 2'h1;
  localparam logic [1:0]  RSOC_AUX_PLL       = 2'h2;
  localparam logic [1:0]  RSOC_AUX_LOCK      = 2'h3;
  // Wait after loss of the sync input clock, in timing clock cycles
  localparam int          RSOC_LOSS_WAIT_LOG2 = 23;
  localparam int          RSOC_LOSS_WAIT_CYC  = 1 << RSOC_LOSS_WAIT_LOG2;
  localparam int          RSOC_WAIT_W         = RSOC_LOSS_WAIT_LOG2 + 1;

  typedef enum logic [1:0]
  {
    RSOC_SRC_STATIC  = 2'b00,
    RSOC_SRC_DYNAMIC = 2'b01,
    RSOC_SRC_WAIT    = 2'b10
  } rsoc_src_t;

endpackage

/* rtl/rsoc_sync2.sv */
// Two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module rsoc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule
`default_nettype wire

/* rtl/rsoc_top.sv */
// Ratio, fractional-N source and output control of a clock synthesizer
//
// Functional notes
// RULE1 - Effective ratio is user ratio times multiplier
// RULE2 - Software avoids multipliers that overflow the ratio
// RULE3 - Slot from ratio select, lock select when automatic; code uses the lock select only when automatic and dynamic
// RULE4 - Fractional-N from effective ratio or digital PLL
// RULE5 - Manual mode: set source bit, equal selects
// RULE6 - Automatic: dynamic when sync present, else static
// RULE7 - Wait 2^23 cycles after sync loss before switching
// RULE8 - Automatic when selects differ; source bit ignored
// RULE9 - Dynamic mode uses format chosen by format bit
// RULE10 - Main output high impedance while disabled
// RULE11 - Main output low when unlocked unless enabled
// RULE12 - Aux mux: reference, sync, PLL clock, lock
// RULE13 - Lock on aux: drive config picks type, polarity
// RULE14 - Aux output high impedance while disabled
// RULE15 - Output switching never makes runt clock periods
// RULE16 - Listed exceptions may give partial clock periods
// RULE17 - Changing ratio fields forces the PLL unlocked
// RULE18 - Reference or sync discontinuities force unlock; code ignores sync ones while skip_ok is set
// RULE19 - Outputs stay low until ratio configured
// RULE20 - Software sets both configuration enable bits
// RULE21 - Held settings applied together on hold release
// RULE22 - Multiplier codes map to 1..8 and 1/2..1/16
// RULE23 - 20.12 only when format bit clear and dynamic
`timescale 1ns/1ns
`default_nettype none
module rsoc_top
  import rsoc_pkg::*;
#(
  parameter int RATIO_W   = RSOC_RATIO_W,
  parameter int WAIT_CYC  = RSOC_LOSS_WAIT_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Host controls
  input  wire logic [RATIO_W-1:0]   user_ratio_0,
  input  wire logic [RATIO_W-1:0]   user_ratio_1,
  input  wire logic [RATIO_W-1:0]   user_ratio_2,
  input  wire logic [RATIO_W-1:0]   user_ratio_3,
  input  wire logic [1:0]           ratio_slot_select,
  input  wire logic [1:0]           input_lock_ratio_select,
  input  wire logic                 synth_source_select,
  input  wire logic                 ratio_format_select,
  input  wire logic [2:0]           ratio_multiplier_select,
  input  wire logic [1:0]           reference_divider_select,
  input  wire logic                 main_output_disable,
  input  wire logic                 output_on_unlock_enable,
  input  wire logic [1:0]           aux_output_source,
  input  wire logic                 aux_output_disable,
  input  wire logic                 lock_indicator_drive_config,
  input  wire logic                 config_enable_first,
  input  wire logic                 config_enable_second,
  input  wire logic                 update_hold,
  input  wire logic                 ratio_valid,
  // Sampled clock and status levels from the analogue side
  input  wire logic                 internal_reference_clock,
  input  wire logic                 sync_input_clock,
  input  wire logic                 pll_clock,
  input  wire logic                 sync_present,
  input  wire logic                 pll_locked,
  input  wire logic                 ref_discontinuity,
  input  wire logic                 sync_discontinuity,
  input  wire logic                 skip_ok,
  input  wire logic [RATIO_W-1:0]   dpll_ratio,
  // Results
  output logic [RATIO_W-1:0]        effective_ratio,
  output logic [RATIO_W-1:0]        frac_n_value,
  output logic                      dynamic_mode,
  output logic                      high_mult_format,
  output logic                      auto_mode,
  output logic                      force_unlock,
  output logic                      main_out,
  output logic                      main_out_oe,
  output logic                      aux_out,
  output logic                      aux_out_oe
);

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn_in;
  logic ref_s, sin_s, pll_s, pres_s, lock_s, rdis_s, sdis_s, skip_s;

  assign raw_in = {internal_reference_clock, sync_input_clock, pll_clock,
                   sync_present, pll_locked, ref_discontinuity,
                   sync_discontinuity, skip_ok};
  assign {ref_s, sin_s, pll_s, pres_s, lock_s, rdis_s, sdis_s, skip_s} =
    syn_in;

  rsoc_sync2 #(
    .W        (NSYNC)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (raw_in),
    .sync_out (syn_in)
  );

  // --------------------------------------------------------------------
  // Held configuration
  // --------------------------------------------------------------------
  localparam int CFG_W = 4 * RATIO_W + 11;
  logic [CFG_W-1:0] cfg_in;
  logic [CFG_W-1:0] cfg_d;
  logic [CFG_W-1:0] cfg_q;
  logic             cfg_chg;
  logic             configured_d;
  logic             configured_q;

  assign cfg_in = {user_ratio_3, user_ratio_2, user_ratio_1, user_ratio_0,
                   ratio_slot_select, input_lock_ratio_select,
                   synth_source_select, ratio_format_select,
                   ratio_multiplier_select, reference_divider_select};

  always_comb
  begin
    cfg_d = update_hold ? cfg_q : cfg_in; // see RULE21
    cfg_chg = (cfg_d != cfg_q); // see RULE17
    configured_d = configured_q |
      (ratio_valid & config_enable_first & config_enable_second); // see RULE19
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q        <= '0;
      configured_q <= 1'b0;
    end
    else
    begin
      cfg_q        <= cfg_d;
      configured_q <= configured_d;
    end
  end

  logic [RATIO_W-1:0] slot_q [RSOC_RATIO_SLOTS];
  logic [1:0]         rsel_h;
  logic [1:0]         lsel_h;
  logic               src_h;
  logic               fmt_h;
  logic [2:0]         rmod_h;

  genvar g;
  generate
    for (g = 0; g < RSOC_RATIO_SLOTS; g++)
    begin : g_slot
      assign slot_q[g] = cfg_q[11 + g*RATIO_W +: RATIO_W];
    end
  endgenerate

  assign rsel_h = cfg_q[10:9];
  assign lsel_h = cfg_q[8:7];
  assign src_h  = cfg_q[6];
  assign fmt_h  = cfg_q[5];
  assign rmod_h = cfg_q[4:2];

  // --------------------------------------------------------------------
  // Source selection state
  // --------------------------------------------------------------------
  rsoc_src_t              st_q;
  rsoc_src_t              st_d;
  logic [RSOC_WAIT_W-1:0] wait_q;
  logic [RSOC_WAIT_W-1:0] wait_d;
  logic                   auto_en;
  logic                   dyn;

  assign auto_en = (lsel_h != rsel_h); // see RULE8

  always_comb
  begin
    st_d   = st_q;
    wait_d = wait_q;
    case (st_q)
      RSOC_SRC_STATIC:
      begin
        if (pres_s)
          st_d = RSOC_SRC_DYNAMIC;
      end
      RSOC_SRC_DYNAMIC:
      begin
        if (!pres_s)
        begin
          st_d   = RSOC_SRC_WAIT;
          wait_d = '0;
        end
      end
      RSOC_SRC_WAIT:
      begin
        if (pres_s)
          st_d = RSOC_SRC_DYNAMIC;
        else if (wait_q >= RSOC_WAIT_W'(WAIT_CYC - 1)) // see RULE7
          st_d = RSOC_SRC_STATIC;
        else
          wait_d = wait_q + RSOC_WAIT_W'(1);
      end
      default:
        st_d = RSOC_SRC_STATIC;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q   <= RSOC_SRC_STATIC;
      wait_q <= '0;
    end
    else
    begin
      st_q   <= st_d;
      wait_q <= wait_d;
    end
  end

  // Automatic follows the sync clock, manual follows the source bit
  assign dyn = auto_en ? (st_q != RSOC_SRC_STATIC) : src_h; // see RULE6

  // --------------------------------------------------------------------
  // Effective ratio and fractional-N value
  // --------------------------------------------------------------------
  logic [1:0]         slot_sel;
  logic [RATIO_W-1:0] ud;
  logic               hm_fmt;
  logic [RATIO_W-1:0] ud_norm;
  logic [RATIO_W-1:0] eff;
  logic [RATIO_W-1:0] eff_q;
  logic [RATIO_W-1:0] fn_q;
  logic [RATIO_W-1:0] fn_d;

  always_comb
  begin
    // Dynamic mode in automatic operation takes the lock slot
    slot_sel = (auto_en && dyn) ? lsel_h : rsel_h; // see RULE3
    ud       = slot_q[slot_sel];
    hm_fmt   = dyn && !fmt_h; // see RULE9 see RULE23
    ud_norm  = hm_fmt ? (ud << RSOC_FMT_SHIFT) : ud;
    case (rmod_h) // see RULE22
      3'h0: eff = ud_norm;
      3'h1: eff = ud_norm << 1;
      3'h2: eff = ud_norm << 2;
      3'h3: eff = ud_norm << 3;
      3'h4: eff = ud_norm >> 1;
      3'h5: eff = ud_norm >> 2;
      3'h6: eff = ud_norm >> 3;
      3'h7: eff = ud_norm >> 4;
      default: eff = ud_norm;
    endcase
    // Divider compensation is inside the synthesizer, so none here
    fn_d = dyn ? dpll_ratio : eff; // see RULE1 see RULE4
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      eff_q <= '0;
      fn_q  <= '0;
    end
    else
    begin
      eff_q <= eff;
      fn_q  <= fn_d;
    end
  end

  assign effective_ratio  = eff_q;
  assign frac_n_value     = fn_q;
  assign dynamic_mode     = dyn;
  assign high_mult_format = hm_fmt;
  assign auto_mode        = auto_en;

  // --------------------------------------------------------------------
  // Unlock and outputs
  // --------------------------------------------------------------------
  logic unl_d;
  logic unl_q;
  logic locked;
  logic main_d;
  logic main_q;
  logic aux_d;
  logic aux_q;
  logic aux_oe_d;
  logic aux_oe_q;
  logic main_oe_d;
  logic main_oe_q;
  logic lock_ind;
  logic pll_prev_d;
  logic pll_prev_q;

  always_comb
  begin
    unl_d = cfg_chg | rdis_s | (sdis_s & !skip_s); // see RULE17 see RULE18
    locked = lock_s & !unl_q;
    // Starts only at a rising clock and stops in its low phase: no runt
    main_d = main_q;
    if (!pll_s)
      main_d = 1'b0;
    else if (!main_q && !pll_prev_q && configured_q &&
             (locked || output_on_unlock_enable))
      main_d = 1'b1; // see RULE11 see RULE15
    pll_prev_d = pll_s;
    main_oe_d = !main_output_disable; // see RULE10
    lock_ind  = lock_indicator_drive_config ? !locked : locked; // see RULE13
    case (aux_output_source) // see RULE12
      RSOC_AUX_REF:  aux_d = ref_s;
      RSOC_AUX_SYNC: aux_d = sin_s; // see RULE16
      RSOC_AUX_PLL:  aux_d = main_d; // see RULE15
      RSOC_AUX_LOCK: aux_d = lock_ind;
      default:       aux_d = 1'b0;
    endcase
    if (!configured_q)
      aux_d = 1'b0; // see RULE19
    // Open-drain style lock drive only actively pulls low
    aux_oe_d = !aux_output_disable &&
      !(aux_output_source == RSOC_AUX_LOCK &&
        lock_indicator_drive_config && aux_d); // see RULE14
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      unl_q     <= 1'b1;
      main_q    <= 1'b0;
      main_oe_q <= 1'b0;
      pll_prev_q <= 1'b0;
      aux_q     <= 1'b0;
      aux_oe_q  <= 1'b0;
    end
    else
    begin
      unl_q     <= unl_d;
      main_q    <= main_d;
      main_oe_q <= main_oe_d;
      pll_prev_q <= pll_prev_d;
      aux_q     <= aux_d;
      aux_oe_q  <= aux_oe_d;
    end
  end

  assign force_unlock = unl_q;
  assign main_out     = main_q;
  assign main_out_oe  = main_oe_q;
  assign aux_out      = aux_q;
  assign aux_out_oe   = aux_oe_q;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  sequence s_loss;
    $fell(pres_s) && st_q == RSOC_SRC_DYNAMIC && auto_en;
  endsequence

  property p_wait_hold;
    @(posedge clk) disable iff (rst)
      s_loss |=> (st_q == RSOC_SRC_WAIT) [*8];
  endproperty
  a_wait_hold: assert property (p_wait_hold) // see RULE7
    else $error("source left wait too early");

  property p_auto_ignores_src;
    @(posedge clk) disable iff (rst)
      auto_en && st_q == RSOC_SRC_STATIC |-> !dyn;
  endproperty
  a_auto_ignores_src: assert property (p_auto_ignores_src) // see RULE8
    else $error("source bit not ignored in automatic mode");

  property p_manual;
    @(posedge clk) disable iff (rst)
      !auto_en |-> dyn == src_h;
  endproperty
  a_manual: assert property (p_manual) // see RULE5
    else $error("manual source not followed");

  property p_static_fn;
    @(posedge clk) disable iff (rst)
      !dyn |=> fn_q == $past(eff);
  endproperty
  a_static_fn: assert property (p_static_fn) // see RULE1
    else $error("static value not effective ratio");

  property p_main_oe;
    @(posedge clk) disable iff (rst)
      main_output_disable |=> !main_out_oe;
  endproperty
  a_main_oe: assert property (p_main_oe) // see RULE10
    else $error("main driver enabled while disabled");

  property p_unlock_low;
    @(posedge clk) disable iff (rst)
      !main_q && !locked && !output_on_unlock_enable |=> !main_q;
  endproperty
  a_unlock_low: assert property (p_unlock_low) // see RULE11
    else $error("main output toggled while unlocked");

  property p_aux_oe;
    @(posedge clk) disable iff (rst)
      aux_output_disable |=> !aux_out_oe;
  endproperty
  a_aux_oe: assert property (p_aux_oe) // see RULE14
    else $error("aux driver enabled while disabled");

  property p_cfg_unlock;
    @(posedge clk) disable iff (rst)
      cfg_chg |=> force_unlock;
  endproperty
  a_cfg_unlock: assert property (p_cfg_unlock) // see RULE17
    else $error("config change did not force unlock");

  property p_unconfigured_low;
    @(posedge clk) disable iff (rst)
      !configured_q |=> !main_q && !aux_q;
  endproperty
  a_unconfigured_low: assert property (p_unconfigured_low) // see RULE19
    else $error("output active before configuration");

endmodule
`default_nettype wire

/* test/rsoc_host_model.sv */
// Host model that drives the configuration fields of the control block
`timescale 1ns/1ns
`default_nettype none
module rsoc_host_model
  import rsoc_pkg::*;
(
  input  wire logic       clk,
  output var logic [31:0] user_ratio_0,
  output var logic [31:0] user_ratio_1,
  output var logic [31:0] user_ratio_2,
  output var logic [31:0] user_ratio_3,
  output var logic [1:0]  ratio_slot_select,
  output var logic [1:0]  input_lock_ratio_select,
  output var logic        synth_source_select,
  output var logic        ratio_format_select,
  output var logic [2:0]  ratio_multiplier_select,
  output var logic [1:0]  reference_divider_select,
  output var logic        main_output_disable,
  output var logic        output_on_unlock_enable,
  output var logic [1:0]  aux_output_source,
  output var logic        aux_output_disable,
  output var logic        lock_indicator_drive_config,
  output var logic        config_enable_first,
  output var logic        config_enable_second,
  output var logic        update_hold,
  output var logic        ratio_valid
);
  initial
  begin
    user_ratio_0 = 32'h0012_3450;
    user_ratio_1 = 32'h0020_0000;
    user_ratio_2 = 32'h0030_0000;
    user_ratio_3 = 32'h0040_0000;
    {ratio_slot_select, input_lock_ratio_select, synth_source_select} = '0;
    {ratio_format_select, ratio_multiplier_select} = '0;
    {reference_divider_select, main_output_disable} = '0;
    {output_on_unlock_enable, aux_output_source, aux_output_disable} = '0;
    {lock_indicator_drive_config, config_enable_first} = '0;
    {config_enable_second, update_hold, ratio_valid} = '0;
  end

  // -------------------------------------------------------------
  // One field write lands at a falling edge
  // -------------------------------------------------------------
  task automatic set(input string f, input int v);
    @(negedge clk);
    case (f)
      "rsel":  ratio_slot_select = 2'(v);
      "lsel":  input_lock_ratio_select = 2'(v);
      "src":   synth_source_select = v[0];
      "fmt":   ratio_format_select = v[0];
      "mult":  if (v[2] || (64'(user_ratio_0) << v[1:0]) < 64'h1_0000_0000)
                 ratio_multiplier_select = 3'(v);
      "rdiv":  reference_divider_select = 2'(v);
      "mdis":  main_output_disable = v[0];
      "munl":  output_on_unlock_enable = v[0];
      "asrc":  aux_output_source = 2'(v);
      "adis":  aux_output_disable = v[0];
      "lcfg":  lock_indicator_drive_config = v[0];
      "en1":   config_enable_first = v[0];
      "en2":   config_enable_second = v[0];
      "hold":  update_hold = v[0];
      "valid": ratio_valid = v[0];
      default: ;
    endcase
  endtask

  // Manual mode with equal selects, enables written in reverse order
  task automatic init();
    set("rsel", 0);
    set("lsel", 0);
    set("fmt", 1);
    set("en2", 1);
    set("en1", 1);
    set("valid", 1);
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the ratio, source and output control
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rsoc_pkg::*;
  localparam int LOSS_WAIT = 16;
  wire logic [31:0] user_ratio_0, user_ratio_1, user_ratio_2, user_ratio_3;
  wire logic [1:0]  ratio_slot_select, input_lock_ratio_select;
  wire logic [1:0]  reference_divider_select, aux_output_source;
  wire logic [2:0]  ratio_multiplier_select;
  wire logic        synth_source_select, ratio_format_select, update_hold;
  wire logic        main_output_disable, output_on_unlock_enable;
  wire logic        aux_output_disable, lock_indicator_drive_config;
  wire logic        config_enable_first, config_enable_second, ratio_valid;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             internal_reference_clock = 1'b1;
  logic             sync_input_clock = 1'b0;
  logic             pll_clock = 1'b0;
  logic             sync_present = 1'b0;
  logic             pll_locked = 1'b0;
  logic             ref_discontinuity = 1'b0;
  logic             sync_discontinuity = 1'b0;
  logic             skip_ok = 1'b0;
  logic [31:0]      dpll_ratio = 32'h0;
  logic [31:0]      effective_ratio, frac_n_value;
  logic             dynamic_mode, high_mult_format, auto_mode, force_unlock;
  logic             main_out, main_out_oe, aux_out, aux_out_oe;
  int               n_fail = 0;
  int               n_tests = 0;

  always #10 clk = ~clk;
  always @(negedge clk) pll_clock <= ~pll_clock;
  always @(negedge clk) sync_input_clock <= ~sync_input_clock;

  rsoc_host_model host (.clk, .user_ratio_0, .user_ratio_1, .user_ratio_2,
    .user_ratio_3, .ratio_slot_select, .input_lock_ratio_select,
    .synth_source_select, .ratio_format_select, .ratio_multiplier_select,
    .reference_divider_select, .main_output_disable,
    .output_on_unlock_enable, .aux_output_source, .aux_output_disable,
    .lock_indicator_drive_config, .config_enable_first,
    .config_enable_second, .update_hold, .ratio_valid);

  rsoc_top #(.WAIT_CYC(LOSS_WAIT)) dut (.clk, .rst, .user_ratio_0,
    .user_ratio_1, .user_ratio_2, .user_ratio_3, .ratio_slot_select,
    .input_lock_ratio_select, .synth_source_select, .ratio_format_select,
    .ratio_multiplier_select, .reference_divider_select,
    .main_output_disable, .output_on_unlock_enable, .aux_output_source,
    .aux_output_disable, .lock_indicator_drive_config, .config_enable_first,
    .config_enable_second, .update_hold, .ratio_valid,
    .internal_reference_clock, .sync_input_clock, .pll_clock, .sync_present,
    .pll_locked, .ref_discontinuity, .sync_discontinuity, .skip_ok,
    .dpll_ratio, .effective_ratio, .frac_n_value, .dynamic_mode,
    .high_mult_format, .auto_mode, .force_unlock, .main_out, .main_out_oe,
    .aux_out, .aux_out_oe);

  // -------------------------------------------------------------
  // Shared helpers
  // -------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [31:0] scaled(input logic [31:0] r,
                                         input logic [2:0] m);
    return m[2] ? r >> (32'(m[1:0]) + 32'd1) : r << m[1:0];
  endfunction

  task automatic settle();
    repeat (6) @(negedge clk);
  endtask

  // Counts the cycles in which an output is high
  task automatic count(input int sel, input int cyc, output int n);
    n = 0;
    repeat (cyc)
    begin
      @(negedge clk);
      case (sel)
        0:       n += int'(main_out === 1'b1);
        1:       n += int'(main_out_oe === 1'b1);
        2:       n += int'(aux_out === 1'b1);
        3:       n += int'(aux_out_oe === 1'b1);
        default: n += int'(force_unlock === 1'b1);
      endcase
    end
  endtask

  // A negative expectation means toggling
  task automatic look(input string what, input int sel, input int exp);
    int n;
    settle();
    count(sel, 16, n);
    chk(what, (exp < 0) ? 32'(n > 0 && n < 16) : 32'(n),
        (exp < 0) ? 32'd1 : 32'(exp));
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_mult();
    int n;
    logic [2:0] m;
    for (int i = 1; i <= 8; i++)
    begin
      m = 3'(i);
      host.set("mult", int'(m));
      count(4, 8, n);
      chk("unlock on ratio change", 32'(n > 0), 1);
      settle();
      chk("effective", effective_ratio, scaled(user_ratio_0, m));
    end
    host.set("rdiv", 1);
    count(4, 8, n);
    chk("unlock on divider", 32'(n > 0), 1);
    settle();
    chk("divider hidden", effective_ratio, user_ratio_0);
  endtask

  task automatic t_slot();
    logic [31:0] exp;
    for (int s = 3; s >= 0; s--)
    begin
      exp = (s == 0) ? user_ratio_0 : (s == 1) ? user_ratio_1 :
            (s == 2) ? user_ratio_2 : user_ratio_3;
      host.set("rsel", s);
      host.set("lsel", s);
      settle();
      chk("slot ratio", effective_ratio, exp);
      chk("manual mode", auto_mode, 0);
    end
  endtask

  task automatic t_source();
    dpll_ratio = 32'h0abc_def0;
    host.set("src", 1);
    host.set("fmt", 0);
    settle();
    chk("dynamic", dynamic_mode, 1);
    chk("frac from dpll", frac_n_value, dpll_ratio);
    chk("wide format", high_mult_format, 1);
    chk("wide ratio", effective_ratio, user_ratio_0 << RSOC_FMT_SHIFT);
    host.set("fmt", 1);
    settle();
    chk("fine format", high_mult_format, 0);
    host.set("fmt", 0);
    host.set("src", 0);
    settle();
    chk("static", dynamic_mode, 0);
    chk("fine when static", high_mult_format, 0);
    chk("frac static", frac_n_value, user_ratio_0);
  endtask

  task automatic t_auto();
    host.set("lsel", 1);
    sync_present = 1'b1;
    settle();
    chk("auto on", auto_mode, 1);
    chk("auto dynamic", dynamic_mode, 1);
    chk("auto frac", frac_n_value, dpll_ratio);
    sync_present = 1'b0;
    repeat (8) @(negedge clk);
    chk("hold after loss", dynamic_mode, 1);
    repeat (LOSS_WAIT + 8) @(negedge clk);
    chk("static after wait", dynamic_mode, 0);
    chk("static slot", frac_n_value, user_ratio_0);
    host.set("lsel", 0);
  endtask

  task automatic t_outputs();
    look("main toggles", 0, -1);
    host.set("mdis", 1);
    look("main off", 1, 0);
    host.set("mdis", 0);
    pll_locked = 1'b0;
    look("main low unlocked", 0, 0);
    host.set("munl", 1);
    look("main on unlock", 0, -1);
    host.set("munl", 0);
    pll_locked = 1'b1;
    host.set("asrc", 0);
    look("aux ref", 2, 16);
    host.set("asrc", 1);
    look("aux sync", 2, -1);
    host.set("asrc", 2);
    look("aux pll", 2, -1);
    host.set("asrc", 3);
    look("aux lock", 2, 16);
    host.set("lcfg", 1);
    look("aux lock inverted", 2, 0);
    look("aux lock driven", 3, 16);
    pll_locked = 1'b0;
    look("aux lock released", 3, 0);
    pll_locked = 1'b1;
    host.set("adis", 1);
    look("aux off", 3, 0);
  endtask

  task automatic t_hold();
    int n;
    int n2;
    host.set("hold", 1);
    host.set("mult", 1);
    settle();
    chk("held", effective_ratio, user_ratio_0);
    host.set("hold", 0);
    settle();
    chk("applied", effective_ratio, scaled(user_ratio_0, 3'h1));
    host.set("mult", 0);
    settle();
    for (int k = 0; k < 3; k++)
    begin
      skip_ok = (k == 2);
      ref_discontinuity = (k == 0);
      sync_discontinuity = (k > 0);
      count(4, 2, n);
      ref_discontinuity = 1'b0;
      sync_discontinuity = 1'b0;
      count(4, 8, n2);
      chk("unlock on break", 32'(n + n2 > 0), 32'(k < 2));
    end
  endtask

  initial
  begin
    repeat (10) @(negedge clk);
    chk("unlock in reset", force_unlock, 1);
    chk("main oe in reset", main_out_oe, 0);
    rst = 1'b0;
    pll_locked = 1'b1;
    look("main held low", 0, 0);
    look("aux held low", 2, 0);
    host.init();
    t_mult();
    t_slot();
    t_source();
    t_auto();
    t_hold();
    t_outputs();
    tally_and_finish();
  end

  initial
  begin
    #80000;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
